// >>> logic/darsc_ctrl.sv
// Reset and shutdown mode control of a two-channel converter front end
// Functional notes
// RL1: Clear bit forces channel output to zero
// RL2: Soft reset clears only that channel's data
// RL3: No data-ready pulse during soft reset
// RL4: Enabled bitstream sends 0011 in soft reset
// RL5: Soft reset exit keeps phase, realigns pulses
// RL6: Valid output after filter settling time
// RL7: One channel in reset keeps clock running
// RL8: Both cleared gates digital core clock
// RL9: Both cleared keeps input structure clocked
// RL10: Hard reset restores defaults, floats bitstreams
// RL11: Hard reset holds interface; host stays silent
// RL12: Off bit shuts channel, config kept
// RL13: Off clear restarts, pulse after settling
// RL14: Host discards pulses within 1 ms
// RL15: Shut channel outputs zeros, no pulses
// RL16: Shut channel bitstream sends 0011 pattern
// RL17: Shutdown exit keeps phase, clock runs
// RL18: Both off stops input and core clocks
// RL19: Off 11 plus externals gives full shutdown
// RL20: Register port works in full shutdown
// RL21: Any bit cleared re-enables supply monitors
// RL22: Full shutdown exit acts as power-on reset
// RL23: Bit n of each field steers channel n
//
// Local design decisions: the register offsets and the address-and-strobe port.
module darsc_ctrl
  import darsc_pkg::*;
(
  input logic mclk_i,
  input logic rst_i,
  input logic reset_n_i,
  input logic por_i,
  input logic output_word_rate_clock_i,
  input logic [1:0][DARSC_SW-1:0] sample_i,
  input logic [1:0] mod_bit_i,
  input logic [DARSC_AW-1:0] addr_i,
  input logic [DARSC_DW-1:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  output logic [DARSC_DW-1:0] rdata_o,
  output logic [1:0] drdy_o,
  output logic [1:0] modulator_bitstream_out_o,
  output logic [1:0] modulator_bitstream_out_oe_o,
  output darsc_clken_s clk_en_o,
  output logic filter_reset_o,
  output logic iface_reset_o,
  output logic comp_force_o,
  output logic [3:0] comp_code_o
);

  darsc_state_s st_r;
  darsc_state_s st_nxt;
  logic hard;
  logic fsd;
  logic wrc_edge;
  logic mod_step;
  logic [1:0] run;
  logic [1:0] act;
  logic [1:0] fire;
  darsc_stat_s stat;

  // Channel n converts when neither its clear nor its off bit is set
  function automatic logic chan_run(input darsc_cfg_s c, input int n);
    chan_run = !c.chan_clear[n] && !c.chan_off[n]; // RL23
  endfunction

  assign hard = !st_r.rstn_s2 || st_r.por_s2;
  assign fsd = (st_r.cfg.chan_off == 2'b11) && st_r.cfg.ext_reference_select
               && st_r.cfg.ext_clock_select; // RL19
  assign wrc_edge = st_r.wrc_s2 && !st_r.wrc_d;
  assign mod_step = (st_r.div == MOD_DIV_LAST);

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      run[n] = chan_run(st_r.cfg, n);
      act[n] = run[n] && !hard; // RL1 RL12
      fire[n] = act[n] && wrc_edge && (st_r.settle[n] <= 2'h1); // RL6 RL13
    end
  end

  // Clock distribution follows the pair of channel states
  always_comb begin
    clk_en_o.core_clk = |run; // RL7 RL8
    clk_en_o.input_clk = (st_r.cfg.chan_off != 2'b11); // RL9 RL18
    clk_en_o.supply_mon = !fsd; // RL21
    clk_en_o.int_ref = !fsd; // RL19
    clk_en_o.bias = ~st_r.cfg.chan_off; // RL12 RL13
  end

  always_comb begin
    stat.settled[0] = act[0] && (st_r.settle[0] == 2'h0);
    stat.settled[1] = act[1] && (st_r.settle[1] == 2'h0);
    stat.active = act;
    stat.mon_en = clk_en_o.supply_mon;
    stat.full_sd = fsd;
    stat.input_clk = clk_en_o.input_clk;
    stat.core_clk = clk_en_o.core_clk;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rstn_s1 = reset_n_i;
    st_nxt.rstn_s2 = st_r.rstn_s1;
    st_nxt.por_s1 = por_i;
    st_nxt.por_s2 = st_r.por_s1;
    st_nxt.wrc_s1 = output_word_rate_clock_i;
    st_nxt.wrc_s2 = st_r.wrc_s1;
    st_nxt.wrc_d = st_r.wrc_s2;
    st_nxt.drdy = 2'b00;
    st_nxt.rdata = '0;
    if (hard) begin
      // Interface held, every register back to default
      st_nxt.cfg = CFG_RESET; // RL10 RL11
      st_nxt.phase = PHASE_RESET;
      st_nxt.data = '0;
      st_nxt.settle = {SETTLE_PERIODS, SETTLE_PERIODS};
      st_nxt.ph_pend = 1'b0;
      st_nxt.ph_cnt = 8'h00;
      st_nxt.fsd_d = 1'b0;
      st_nxt.div = 2'h0;
      st_nxt.pat_idx = 2'h0;
      st_nxt.bit_out = 2'b00;
      st_nxt.bit_oe = 2'b00; // RL10
    end else begin
      st_nxt.fsd_d = fsd;
      // Register port stays alive in every mode but hard reset, full shutdown included
      if (wr_i) begin // RL20
        unique case (addr_i)
          CFG_OFS: st_nxt.cfg = darsc_cfg_s'(wdata_i[7:0]);
          PHASE_OFS: st_nxt.phase = wdata_i[7:0];
          default: ;
        endcase
      end
      if (rd_i) begin // RL20
        unique case (addr_i)
          CFG_OFS: st_nxt.rdata = {24'h000000, st_r.cfg};
          PHASE_OFS: st_nxt.rdata = {24'h000000, st_r.phase};
          DATA0_OFS: st_nxt.rdata = {8'h00, st_r.data[0]};
          DATA1_OFS: st_nxt.rdata = {8'h00, st_r.data[1]};
          STATUS_OFS: st_nxt.rdata = {24'h000000, stat};
          default: st_nxt.rdata = '0;
        endcase
      end
      // Leaving full shutdown behaves as a power-on reset
      if (st_r.fsd_d && !fsd) begin
        st_nxt.cfg = CFG_RESET; // RL22
        st_nxt.phase = PHASE_RESET; // RL22
      end
      // Modulator rate divider for the zero pattern
      st_nxt.div = mod_step ? 2'h0 : st_r.div + 2'h1;
      if (mod_step) begin
        st_nxt.pat_idx = st_r.pat_idx + 2'h1;
      end
      for (int n = 0; n < 2; n++) begin
        if (!act[n]) begin
          st_nxt.data[n] = '0; // RL2 RL15
          st_nxt.settle[n] = SETTLE_PERIODS; // RL6 RL13 RL22
        end else if (wrc_edge && (st_r.settle[n] != 2'h0)) begin
          st_nxt.settle[n] = st_r.settle[n] - 2'h1;
        end
        st_nxt.bit_oe[n] = st_r.cfg.mod_en[n];
        if (act[n]) begin
          st_nxt.bit_out[n] = mod_bit_i[n];
        end else begin
          st_nxt.bit_out[n] = ZERO_PATTERN[2'h3 - st_r.pat_idx]; // RL4 RL16
        end
      end
      // Channel 0 pulses on the shared rate edge
      if (fire[0]) begin
        st_nxt.drdy[0] = 1'b1; // RL3 RL15
        st_nxt.data[0] = sample_i[0];
      end
      // Channel 1 pulses the phase count plus one cycle after channel 0, always referenced to the same edge
      if (!act[1]) begin
        st_nxt.ph_pend = 1'b0; // RL3 RL15
      end else if (st_r.ph_pend) begin
        if (st_r.ph_cnt == 8'h00) begin
          st_nxt.ph_pend = 1'b0;
          st_nxt.drdy[1] = 1'b1; // RL5 RL17
          st_nxt.data[1] = sample_i[1];
        end else begin
          st_nxt.ph_cnt = st_r.ph_cnt - 8'h01;
        end
      end
      if (fire[1]) begin
        st_nxt.ph_pend = 1'b1; // RL5 RL17
        st_nxt.ph_cnt = st_r.phase;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.cfg <= CFG_RESET;
      st_r.phase <= PHASE_RESET;
      st_r.settle <= {SETTLE_PERIODS, SETTLE_PERIODS};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign drdy_o = st_r.drdy;
  assign modulator_bitstream_out_o = st_r.bit_out;
  assign modulator_bitstream_out_oe_o = st_r.bit_oe;
  assign filter_reset_o = hard; // RL10
  assign iface_reset_o = hard; // RL11
  assign comp_force_o = hard; // RL10
  assign comp_code_o = hard ? COMP_RESET_CODE : 4'h0;

  property p_no_drdy0_idle;
    @(posedge mclk_i) disable iff (rst_i)
    drdy_o[0] |-> $past(act[0]);
  endproperty
  a_no_drdy0_idle: assert property (p_no_drdy0_idle) // RL3
    else $error("channel 0 pulsed while held");

  property p_no_drdy1_idle;
    @(posedge mclk_i) disable iff (rst_i)
    drdy_o[1] |-> $past(act[1]) && act[1];
  endproperty
  a_no_drdy1_idle: assert property (p_no_drdy1_idle) // RL15
    else $error("channel 1 pulsed while held");

  property p_data_cleared;
    @(posedge mclk_i) disable iff (rst_i)
    (!act[0] && !act[1]) |=> (st_r.data[0] == '0) && (st_r.data[1] == '0);
  endproperty
  a_data_cleared: assert property (p_data_cleared) // RL2
    else $error("held channel data not cleared");

  property p_zero_stream;
    @(posedge mclk_i) disable iff (rst_i)
    (!hard && !act[0] && $past(!hard && !act[0])) |->
      modulator_bitstream_out_o[0] == ZERO_PATTERN[2'h3 - $past(st_r.pat_idx)];
  endproperty
  a_zero_stream: assert property (p_zero_stream) // RL4
    else $error("zero pattern wrong on channel 0");

  property p_hard_float;
    @(posedge mclk_i) disable iff (rst_i)
    hard |=> (modulator_bitstream_out_oe_o == 2'b00) && (st_r.cfg == CFG_RESET)
      && (rdata_o == '0);
  endproperty
  a_hard_float: assert property (p_hard_float) // RL10
    else $error("hard reset did not restore defaults");

  property p_hard_iface;
    @(posedge mclk_i) disable iff (rst_i)
    (hard && wr_i) |=> (st_r.phase == PHASE_RESET);
  endproperty
  a_hard_iface: assert property (p_hard_iface) // RL11
    else $error("write accepted during hard reset");

  property p_phase_delay;
    @(posedge mclk_i) disable iff (rst_i)
    (!hard && act[1] && st_r.ph_pend && (st_r.ph_cnt == 8'h00) && !fire[1]) |=> drdy_o[1];
  endproperty
  a_phase_delay: assert property (p_phase_delay) // RL5
    else $error("delayed pulse missing on channel 1");

  property p_settle;
    @(posedge mclk_i) disable iff (rst_i)
    drdy_o[0] |-> $past(st_r.settle[0]) <= 2'h1;
  endproperty
  a_settle: assert property (p_settle) // RL13
    else $error("pulse before filter settling");

  property p_core_gate;
    @(posedge mclk_i) disable iff (rst_i)
    (st_r.cfg.chan_clear == 2'b11) |-> !clk_en_o.core_clk;
  endproperty
  a_core_gate: assert property (p_core_gate) // RL8
    else $error("core clock running with both channels cleared");

  property p_input_clk;
    @(posedge mclk_i) disable iff (rst_i)
    (st_r.cfg.chan_off != 2'b11) |-> clk_en_o.input_clk;
  endproperty
  a_input_clk: assert property (p_input_clk) // RL9
    else $error("input structure clock stopped");

  property p_both_off;
    @(posedge mclk_i) disable iff (rst_i)
    (st_r.cfg.chan_off == 2'b11) |-> !clk_en_o.input_clk && !clk_en_o.core_clk;
  endproperty
  a_both_off: assert property (p_both_off) // RL18
    else $error("clocks distributed with both channels off");

  property p_fsd_mon;
    @(posedge mclk_i) disable iff (rst_i)
    fsd |-> !clk_en_o.supply_mon && !clk_en_o.int_ref;
  endproperty
  a_fsd_mon: assert property (p_fsd_mon) // RL19
    else $error("monitors on in full shutdown");

  property p_fsd_read;
    @(posedge mclk_i) disable iff (rst_i)
    (!hard && fsd && rd_i && (addr_i == CFG_OFS)) |=> rdata_o[7:0] == $past(st_r.cfg);
  endproperty
  a_fsd_read: assert property (p_fsd_read) // RL20
    else $error("register read failed in full shutdown");

  property p_fsd_exit;
    @(posedge mclk_i) disable iff (rst_i)
    (!hard && $fell(fsd)) |=> (st_r.cfg == CFG_RESET) ##1 !drdy_o[0];
  endproperty
  a_fsd_exit: assert property (p_fsd_exit) // RL22
    else $error("full shutdown exit kept configuration");

endmodule

// >>> logic/darsc_pkg.sv
// Constants, register map and carrier types of the dual converter mode controller
package darsc_pkg;

  localparam int unsigned DARSC_AW = 8;
  localparam int unsigned DARSC_DW = 32;
  localparam int unsigned DARSC_SW = 24;

  // Register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] PHASE_OFS = 8'h04;
  localparam logic [7:0] DATA0_OFS = 8'h08;
  localparam logic [7:0] DATA1_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Configuration word, bit n of each two-bit field steers channel n
  typedef struct packed {
    logic [1:0] mod_en;
    logic ext_clock_select;
    logic ext_reference_select;
    logic [1:0] chan_off;
    logic [1:0] chan_clear;
  } darsc_cfg_s;

  typedef struct packed {
    logic [1:0] settled;
    logic [1:0] active;
    logic mon_en;
    logic full_sd;
    logic input_clk;
    logic core_clk;
  } darsc_stat_s;

  typedef struct packed {
    logic [1:0] bias;
    logic int_ref;
    logic supply_mon;
    logic input_clk;
    logic core_clk;
  } darsc_clken_s;

  // Values after reset
  localparam darsc_cfg_s CFG_RESET = '0;
  localparam logic [7:0] PHASE_RESET = 8'h00;

  // Counts
  localparam logic [1:0] SETTLE_PERIODS = 2'h3;
  localparam logic [1:0] MOD_DIV_LAST = 2'h3;

  // Zero stream pattern and comparator reset code
  localparam logic [3:0] ZERO_PATTERN = 4'h3;
  localparam logic [3:0] COMP_RESET_CODE = 4'h3;

  typedef struct packed {
    logic rstn_s1;
    logic rstn_s2;
    logic por_s1;
    logic por_s2;
    logic wrc_s1;
    logic wrc_s2;
    logic wrc_d;
    darsc_cfg_s cfg;
    logic [7:0] phase;
    logic [1:0][DARSC_SW-1:0] data;
    logic [1:0][1:0] settle;
    logic [7:0] ph_cnt;
    logic ph_pend;
    logic fsd_d;
    logic [1:0] div;
    logic [1:0] pat_idx;
    logic [DARSC_DW-1:0] rdata;
    logic [1:0] drdy;
    logic [1:0] bit_out;
    logic [1:0] bit_oe;
  } darsc_state_s;

endpackage

// >>> test/darsc_front_model.sv
// Converter front-end stand-in: rate clock, results and modulator bits
module darsc_front_model (
  input wire logic mclk_i,
  output logic rate_clk_o,
  output logic [1:0][23:0] sample_o,
  output logic [1:0] mod_bit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed = 68;
  initial begin
    rate_clk_o = 1'b0;
    sample_o = '0;
    mod_bit_o = 2'h0;
    forever begin
      #80 rate_clk_o = ~rate_clk_o;
      // New results only while low, stable around the rising edge
      if (!rate_clk_o) begin
        sample_o[0] = 24'($random(seed));
        sample_o[1] = 24'($random(seed));
      end
    end
  end
  always @(posedge mclk_i) begin
    mod_bit_o <= 2'($random(seed));
  end
endmodule

// >>> test/tb.sv
// Self-checking bench of the converter mode controller
module tb;
  import darsc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i, rst_i, reset_n_i, por_i, wr_i, rd_i, rate_clk, if_rst, f_rst, c_force;
  logic [1:0][DARSC_SW-1:0] sample;
  logic [1:0] mod_bit, drdy, bs, bs_oe;
  logic [7:0] addr_i, bits;
  logic [31:0] wdata_i, rdata, d;
  logic [3:0] c_code;
  darsc_clken_s ce;
  int fails = 0, n_checks = 0, cyc = 0, cnt0 = 0, cnt1 = 0, i, c;
  integer seed = 68;

  darsc_front_model model (.mclk_i(mclk_i), .rate_clk_o(rate_clk), .sample_o(sample),
    .mod_bit_o(mod_bit));
  darsc_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .por_i(por_i),
    .output_word_rate_clock_i(rate_clk), .sample_i(sample), .mod_bit_i(mod_bit),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .drdy_o(drdy), .modulator_bitstream_out_o(bs), .modulator_bitstream_out_oe_o(bs_oe),
    .clk_en_o(ce), .filter_reset_o(f_rst), .iface_reset_o(if_rst), .comp_force_o(c_force),
    .comp_code_o(c_code));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    cnt0 <= cnt0 + int'(drdy[0]);
    cnt1 <= cnt1 + int'(drdy[1]);
    if (cyc == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  task automatic wait_dr(input int k, input int lim);
    c = 0;
    do begin
      @(posedge mclk_i);
      #1;
      c++;
    end while (drdy[k] !== 1'b1 && c < lim);
  endtask

  // Program a phase, then measure the channel 1 lag behind channel 0
  task automatic align(input logic [7:0] p);
    logic [23:0] s;
    wr(PHASE_OFS, {24'h0, p});
    repeat (70) @(posedge mclk_i);
    wait_dr(0, 40);
    wait_dr(1, 40);
    s = sample[1];
    // Channel 1 lags channel 0 by the phase count plus the load cycle
    chk(c, 32'(p) + 32'h1);
    rchk(DATA1_OFS, {8'h0, s});
    $display("done: align phase %0d", p);
  endtask

  // Park channel k by cfg value v; the other channel keeps converting
  task automatic park(input int k, input logic [31:0] v);
    int a0, a1;
    wr(CFG_OFS, v);
    a0 = cnt0;
    a1 = cnt1;
    repeat (60) @(posedge mclk_i);
    chk(k ? cnt1 - a1 : cnt0 - a0, 0);
    chk(k ? cnt0 - a0 : cnt1 - a1, 3);
    chk(ce.core_clk, 1'b1);
    rchk(k ? DATA1_OFS : DATA0_OFS, 0);
    rchk(CFG_OFS, v);
    chk(bs_oe[k], 1'b1);
    for (i = 0; i < 8; i++) begin
      repeat (4) @(posedge mclk_i);
      #1 bits[i] = bs[k];
    end
    chk({bits[3:0] == bits[7:4], bits[0] ^ bits[2], bits[1] ^ bits[3]}, 3'h7);
    $display("done: park channel %0d", k);
  endtask

  initial begin
    rst_i = 1'b1;
    reset_n_i = 1'b1;
    por_i = 1'b0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rchk(CFG_OFS, 0);
    rchk(8'h14, 0);
    align(8'h1 + 8'($unsigned($random(seed)) % 18));
    align(8'd18);
    park(0, 32'h41);
    wr(CFG_OFS, 32'h03);
    chk({ce.input_clk, ce.core_clk}, 2'h2);
    wr(CFG_OFS, 32'h02);
    chk(ce.core_clk, 1'b1);
    wait_dr(0, 100);
    chk(c > 40 && c <= 66, 1'b1);
    wr(CFG_OFS, 32'h00);
    align(8'd7);
    park(1, 32'h88);
    wr(CFG_OFS, 32'h0c);
    chk({ce.input_clk, ce.core_clk}, 2'h0);
    wr(CFG_OFS, 32'h3c);
    chk({ce.supply_mon, ce.int_ref}, 2'h0);
    rd(STATUS_OFS);
    chk(d[2], 1'b1);
    wr(CFG_OFS, 32'h38);
    chk(ce.supply_mon, 1'b1);
    rchk(CFG_OFS, 0);
    rchk(PHASE_OFS, 0);
    wait_dr(0, 100);
    chk(c >= 36 && c <= 66, 1'b1);
    $display("done: shutdown");
    for (int s = 0; s < 2; s++) begin
      wr(CFG_OFS, 32'hc0);
      reset_n_i <= s[0];
      por_i <= s[0];
      repeat (4) @(posedge mclk_i);
      #1;
      chk({if_rst, f_rst, c_force, c_code, bs_oe, drdy}, 11'h730);
      reset_n_i <= 1'b1;
      por_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rchk(CFG_OFS, 0);
      rchk(DATA0_OFS, 0);
    end
    $display("done: hard reset");
    end_sim();
  end
endmodule
